// File: shared/spc_pkg.sv
// Constants and types shared by the presettable counter design
package spc_pkg;

    // Counter geometry
    localparam int SPC_W = 4;
    typedef logic [SPC_W-1:0] spc_count_t;
    localparam spc_count_t SPC_ZERO = 4'h0;
    localparam spc_count_t SPC_MAX  = 4'hf;
    localparam spc_count_t SPC_STEP = 4'h1;

    // Register bus geometry
    localparam int SPC_AW = 4;
    localparam int SPC_DW = 32;
    typedef logic [SPC_AW-1:0] spc_addr_t;
    typedef logic [SPC_DW-1:0] spc_data_t;

    // Register byte offsets
    localparam spc_addr_t SPC_OFF_CTRL   = 4'h0;
    localparam spc_addr_t SPC_OFF_PRESET = 4'h4;
    localparam spc_addr_t SPC_OFF_STATUS = 4'h8;

    // Control register fields (write-one strobes, read as zero)
    localparam int SPC_CTRL_CLEAR_BIT = 0;
    localparam int SPC_CTRL_LOAD_BIT  = 1;

    // Status register fields
    localparam int SPC_ST_COUNT_LSB   = 0;
    localparam int SPC_ST_CARRY_BIT   = 4;
    localparam int SPC_ST_CGATE_BIT   = 5;
    localparam int SPC_ST_KGATE_BIT   = 6;

    // Reset values
    localparam spc_count_t SPC_PRESET_RST = 4'h0;
    localparam spc_data_t  SPC_DATA_ZERO  = 32'h0000_0000;
    localparam spc_addr_t  SPC_ADDR_ZERO  = 4'h0;

    // Bus responses
    localparam logic [1:0] SPC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SPC_RESP_SLVERR = 2'h2;

    // One clock edge worth of counter command; the core applies the priority
    typedef struct packed {
        logic       clear;
        logic       load;
        logic       enable;
        spc_count_t data;
    } spc_cmd_s;

endpackage : spc_pkg

// File: rtl/spc_carry_dec.sv
// Terminal-carry decode for one counter stage
`timescale 1ns/1ns
module spc_carry_dec
    import spc_pkg::*;
#(
    parameter int W = SPC_W
)
(
    // Stage state
    input  wire logic [W-1:0] count,
    input  wire logic         carry_gate,
    // Decode
    output logic              carry
);

    // Gate enters only here so a cascade needs no extra logic downstream
    assign carry = (&count) & carry_gate;

endmodule : spc_carry_dec

// File: rtl/spc_cnt_core.sv
// Four-bit synchronous presettable counter core
`timescale 1ns/1ns
module spc_cnt_core
    import spc_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Command for this edge
    input  spc_cmd_s        cmd,
    // State
    output spc_count_t      count_r
);

    spc_count_t count_nxt;

    // Clear beats load, load beats counting, else hold
    always_comb
    begin
        if (cmd.clear)
        begin
            count_nxt = SPC_ZERO;
        end
        else if (cmd.load)
        begin
            count_nxt = cmd.data;
        end
        else if (cmd.enable)
        begin
            // Plain binary step; fifteen wraps to zero by width
            count_nxt = spc_count_t'(count_r + SPC_STEP);
        end
        else
        begin
            count_nxt = count_r;
        end
    end

    // All bits share one edge, so outputs never show ripple values
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_r <= SPC_ZERO;
        end
        else
        begin
            count_r <= count_nxt;
        end
    end

endmodule : spc_cnt_core

// File: rtl/spc_counter_top.sv
// Presettable counter with pin controls and an AXI4-Lite register slave
`timescale 1ns/1ns
module spc_counter_top
    import spc_pkg::*;
(
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Counter control pins
    input  wire logic         sync_zero_n,
    input  wire logic         preset_load_n,
    input  wire logic [3:0]   preset_data,
    input  wire logic         count_gate_in,
    input  wire logic         carry_gate_in,
    // Counter outputs
    output logic              count_out_bit0,
    output logic              count_out_bit1,
    output logic              count_out_bit2,
    output logic              count_out_bit3,
    output logic              terminal_carry_out,
    // AXI4-Lite write address
    input  wire logic [3:0]   s_axil_awaddr,
    input  wire logic         s_axil_awvalid,
    output logic              s_axil_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]  s_axil_wdata,
    input  wire logic [3:0]   s_axil_wstrb,
    input  wire logic         s_axil_wvalid,
    output logic              s_axil_wready,
    // AXI4-Lite write response
    output logic [1:0]        s_axil_bresp,
    output logic              s_axil_bvalid,
    input  wire logic         s_axil_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]   s_axil_araddr,
    input  wire logic         s_axil_arvalid,
    output logic              s_axil_arready,
    // AXI4-Lite read data
    output logic [31:0]       s_axil_rdata,
    output logic [1:0]        s_axil_rresp,
    output logic              s_axil_rvalid,
    input  wire logic         s_axil_rready
);

    spc_cmd_s   cmd;
    spc_count_t count_r;
    logic       carry;

    logic       awready_r;
    logic       wready_r;
    logic       bvalid_r;
    logic [1:0] bresp_r;
    logic       arready_r;
    logic       rvalid_r;
    logic [1:0] rresp_r;
    spc_data_t  rdata_r;

    logic       aw_got_r;
    logic       w_got_r;
    spc_addr_t  waddr_r;
    spc_data_t  wdata_r;
    logic [3:0] wstrb_r;
    logic       wr_go;

    spc_count_t preset_r;
    logic       sw_clear_r;
    logic       sw_load_r;

    // Command assembly: pins and software strobes share one priority
    always_comb
    begin
        cmd.clear  = !sync_zero_n || sw_clear_r;
        cmd.load   = !preset_load_n || sw_load_r;
        cmd.enable = count_gate_in && carry_gate_in;
        // A pin load on the same edge wins over the software preset
        cmd.data   = preset_load_n ? preset_r : preset_data;
    end

    spc_cnt_core u_core (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cmd     (cmd),
        .count_r (count_r)
    );

    spc_carry_dec #(
        .W (SPC_W)
    ) u_carry (
        .count      (count_r),
        .carry_gate (carry_gate_in),
        .carry      (carry)
    );

    // Bit n of the count drives output n
    assign count_out_bit0 = count_r[0];
    assign count_out_bit1 = count_r[1];
    assign count_out_bit2 = count_r[2];
    assign count_out_bit3 = count_r[3];
    // Kept combinational so a cascaded stage sees the gate with no lag
    assign terminal_carry_out = carry;

    assign s_axil_awready = awready_r;
    assign s_axil_wready  = wready_r;
    assign s_axil_bvalid  = bvalid_r;
    assign s_axil_bresp   = bresp_r;
    assign s_axil_arready = arready_r;
    assign s_axil_rvalid  = rvalid_r;
    assign s_axil_rresp   = rresp_r;
    assign s_axil_rdata   = rdata_r;

    // Write commits once both address and data have been captured
    assign wr_go = aw_got_r && w_got_r && !bvalid_r;

    // Write address channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_r <= 1'b1;
            aw_got_r  <= 1'b0;
            waddr_r   <= SPC_ADDR_ZERO;
        end
        else if (s_axil_awvalid && awready_r)
        begin
            awready_r <= 1'b0;
            aw_got_r  <= 1'b1;
            waddr_r   <= s_axil_awaddr;
        end
        else if (wr_go)
        begin
            aw_got_r  <= 1'b0;
        end
        else if (bvalid_r && s_axil_bready)
        begin
            awready_r <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wready_r <= 1'b1;
            w_got_r  <= 1'b0;
            wdata_r  <= SPC_DATA_ZERO;
            wstrb_r  <= 4'h0;
        end
        else if (s_axil_wvalid && wready_r)
        begin
            wready_r <= 1'b0;
            w_got_r  <= 1'b1;
            wdata_r  <= s_axil_wdata;
            wstrb_r  <= s_axil_wstrb;
        end
        else if (wr_go)
        begin
            w_got_r  <= 1'b0;
        end
        else if (bvalid_r && s_axil_bready)
        begin
            wready_r <= 1'b1;
        end
    end

    // Write response; status is read-only so a write there is refused
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r  <= SPC_RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_r <= 1'b1;
            if (waddr_r == SPC_OFF_CTRL)
            begin
                bresp_r <= SPC_RESP_OKAY;
            end
            else if (waddr_r == SPC_OFF_PRESET)
            begin
                bresp_r <= SPC_RESP_OKAY;
            end
            else
            begin
                bresp_r <= SPC_RESP_SLVERR;
            end
        end
        else if (bvalid_r && s_axil_bready)
        begin
            bvalid_r <= 1'b0;
        end
    end

    // Preset holding register, byte lane 0 only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            preset_r <= SPC_PRESET_RST;
        end
        else if (wr_go && waddr_r == SPC_OFF_PRESET && wstrb_r[0])
        begin
            preset_r <= wdata_r[SPC_W-1:0];
        end
    end

    // Software strobes last one cycle and act at the following edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sw_clear_r <= 1'b0;
            sw_load_r  <= 1'b0;
        end
        else if (wr_go && waddr_r == SPC_OFF_CTRL && wstrb_r[0])
        begin
            sw_clear_r <= wdata_r[SPC_CTRL_CLEAR_BIT];
            sw_load_r  <= wdata_r[SPC_CTRL_LOAD_BIT];
        end
        else
        begin
            sw_clear_r <= 1'b0;
            sw_load_r  <= 1'b0;
        end
    end

    // Read channel; status is sampled at the address handshake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= SPC_RESP_OKAY;
            rdata_r   <= SPC_DATA_ZERO;
        end
        else if (s_axil_arvalid && arready_r)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rresp_r   <= SPC_RESP_OKAY;
            rdata_r   <= SPC_DATA_ZERO;
            if (s_axil_araddr == SPC_OFF_CTRL)
            begin
                rdata_r <= SPC_DATA_ZERO;
            end
            else if (s_axil_araddr == SPC_OFF_PRESET)
            begin
                rdata_r[SPC_W-1:0] <= preset_r;
            end
            else if (s_axil_araddr == SPC_OFF_STATUS)
            begin
                rdata_r[SPC_ST_COUNT_LSB +: SPC_W] <= count_r;
                rdata_r[SPC_ST_CARRY_BIT] <= carry;
                rdata_r[SPC_ST_CGATE_BIT] <= carry_gate_in;
                rdata_r[SPC_ST_KGATE_BIT] <= count_gate_in;
            end
            else
            begin
                rresp_r <= SPC_RESP_SLVERR;
            end
        end
        else if (rvalid_r && s_axil_rready)
        begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_clear_zero: assert property (
        cmd.clear |=> count_r == SPC_ZERO)
        else $error("clear did not zero the count");

    a_clear_over_load: assert property (
        cmd.clear && cmd.load && cmd.enable |=> count_r == SPC_ZERO)
        else $error("clear lost priority");

    a_load_value: assert property (
        !cmd.clear && cmd.load |=> count_r == $past(cmd.data))
        else $error("load did not copy preset data");

    a_load_over_count: assert property (
        !cmd.clear && cmd.load && cmd.enable && cmd.data != count_r
        |=> count_r != spc_count_t'($past(count_r) + SPC_STEP)
            || count_r == $past(cmd.data))
        else $error("count won over load");

    a_count_step: assert property (
        !cmd.clear && !cmd.load && cmd.enable
        |=> count_r == spc_count_t'($past(count_r) + SPC_STEP))
        else $error("enabled count did not step by one");

    a_count_hold: assert property (
        !cmd.clear && !cmd.load && !cmd.enable |=> $stable(count_r))
        else $error("count moved without a command");

    a_wrap_zero: assert property (
        !cmd.clear && !cmd.load && cmd.enable && count_r == SPC_MAX
        ##1 !cmd.clear && !cmd.load && cmd.enable
        |=> count_r == SPC_STEP)
        else $error("count did not wrap and continue");

    a_carry_out: assert property (
        terminal_carry_out == (count_r == SPC_MAX && carry_gate_in))
        else $error("terminal carry mismatch");

    a_pin_map: assert property (
        {count_out_bit3, count_out_bit2, count_out_bit1, count_out_bit0}
        == count_r)
        else $error("count outputs not mapped bit for bit");

    a_sw_clear: assert property (
        wr_go && waddr_r == SPC_OFF_CTRL && wstrb_r[0]
        && wdata_r[SPC_CTRL_CLEAR_BIT] |=> ##1 count_r == SPC_ZERO)
        else $error("software clear did not zero the count");

    a_bresp_hold: assert property (
        bvalid_r && !s_axil_bready |=> bvalid_r && $stable(bresp_r))
        else $error("write response dropped early");

    a_rd_answer: assert property (
        s_axil_arvalid && arready_r |=> rvalid_r && !arready_r)
        else $error("read not answered next cycle");

    c_load_count: cover property (
        !cmd.clear && cmd.load ##1 (!cmd.load && cmd.enable) [*3]);
    c_wrap: cover property (
        count_r == SPC_MAX && cmd.enable && !cmd.load ##1
        count_r == SPC_ZERO);
    c_sw_write: cover property (wr_go ##1 bvalid_r);
    c_status_read: cover property (
        s_axil_arvalid && arready_r && s_axil_araddr == SPC_OFF_STATUS);

endmodule : spc_counter_top

// File: tb/spc_far_model.sv
// Far side: a cascaded upper stage and a cycle-shortening decoder
`timescale 1ns/1ns
module spc_far_model
    import spc_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Lower stage view
    input  wire logic [3:0] count,
    input  wire logic       carry,
    // Controls from the bench
    input  wire logic       casc_en,
    input  wire logic       short_en,
    input  wire logic [3:0] short_val,
    // Upper stage and decoded clear
    output spc_count_t      upper_r,
    output logic            short_n
);
    // Upper stage steps on the lower carry, gated only by casc_en
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            upper_r <= SPC_ZERO;
        else if (casc_en && carry)
            upper_r <= upper_r + SPC_STEP;
    end

    // Decoder pulls the clear low at the chosen terminal value
    assign short_n = !(short_en && count == short_val);
endmodule : spc_far_model

// File: tb/spc_counter_top_tb.sv
// Self-checking bench for the presettable counter with register slave
`timescale 1ns/1ns
module spc_counter_top_tb
    import spc_pkg::*;
;
    logic        aclk, aresetn, zero_n, load_n, cgate, kgate;
    logic [3:0]  pdata, short_val, awaddr, araddr, wstrb;
    logic [31:0] wdata;
    logic        casc_en, short_en, awvalid, wvalid, bready;
    logic        arvalid, rready;
    wire logic   awready, wready, bvalid, arready, rvalid;
    wire logic   carry, short_n, b0, b1, b2, b3;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    spc_count_t  upper;
    spc_count_t  cnt;
    spc_count_t  ref_cnt, ref_hi;
    int          num_errors = 0;
    int          n_checks = 0;

    assign cnt = {b3, b2, b1, b0};

    spc_counter_top dut (
        .aclk(aclk), .aresetn(aresetn),
        .sync_zero_n(zero_n & short_n), .preset_load_n(load_n),
        .preset_data(pdata), .count_gate_in(cgate),
        .carry_gate_in(kgate),
        .count_out_bit0(b0), .count_out_bit1(b1),
        .count_out_bit2(b2), .count_out_bit3(b3),
        .terminal_carry_out(carry),
        .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
        .s_axil_awready(awready), .s_axil_wdata(wdata),
        .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
        .s_axil_wready(wready), .s_axil_bresp(bresp),
        .s_axil_bvalid(bvalid), .s_axil_bready(bready),
        .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
        .s_axil_arready(arready), .s_axil_rdata(rdata),
        .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
        .s_axil_rready(rready)
    );

    spc_far_model far (
        .aclk(aclk), .aresetn(aresetn), .count(cnt), .carry(carry),
        .casc_en(casc_en), .short_en(short_en), .short_val(short_val),
        .upper_r(upper), .short_n(short_n)
    );

    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task chk(input logic ok, input string m);
        n_checks++;
        if (!ok)
        begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk

    task conclude;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    // Drive pins at an edge, check the previous edge's result mid-cycle
    task automatic step(input logic z, input logic l,
                        input logic [3:0] d, input logic cg,
                        input logic kg);
        logic z_eff;
        zero_n <= z;
        load_n <= l;
        pdata <= d;
        cgate <= cg;
        kgate <= kg;
        @(negedge aclk);
        chk(cnt === ref_cnt, "count");
        chk(carry === (ref_cnt == SPC_MAX && kg), "carry");
        chk(upper === ref_hi, "upper stage");
        z_eff = z && !(short_en && ref_cnt == short_val);
        if (casc_en && ref_cnt == SPC_MAX && kg)
            ref_hi = ref_hi + SPC_STEP;
        if (!z_eff)
            ref_cnt = SPC_ZERO;
        else if (!l)
            ref_cnt = d;
        else if (cg && kg)
            ref_cnt = ref_cnt + SPC_STEP;
        @(posedge aclk);
    endtask : step

    task automatic axw(input spc_addr_t a, input spc_data_t d,
                       input logic [1:0] er);
        int t;
        logic busy;
        t = 0;
        busy = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (busy && t < 200)
        begin
            @(posedge aclk);
            t++;
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bready && bvalid)
            begin
                bready <= 1'b0;
                busy = 1'b0;
                chk(bresp === er, "write response");
            end
        end
        chk(t < 200, "write wait");
    endtask : axw

    task automatic axr(input spc_addr_t a, input spc_data_t ed,
                       input logic [1:0] er);
        int t;
        logic busy;
        t = 0;
        busy = 1'b1;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (busy && t < 200)
        begin
            @(posedge aclk);
            t++;
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rready && rvalid)
            begin
                rready <= 1'b0;
                busy = 1'b0;
                chk(rdata === ed, "read data");
                chk(rresp === er, "read response");
            end
        end
        chk(t < 200, "read wait");
    endtask : axr

    initial
    begin
        #40000;
        num_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        conclude();
    end

    initial
    begin
        {zero_n, load_n, cgate, kgate, pdata} = 8'hc0;
        {casc_en, short_en, short_val} = 6'h00;
        {awaddr, araddr, wstrb, wdata} = {12'h00f, 32'h0};
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        aresetn = 1'b0;
        ref_cnt = SPC_ZERO;
        ref_hi = SPC_ZERO;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        @(posedge aclk);
        step(1'b1, 1'b1, 4'h0, 1'b0, 1'b0);
        for (int v = 0; v < 16; v++)
            step(1'b1, 1'b0, v[3:0], 1'b1, 1'b1);
        step(1'b1, 1'b0, 4'hc, 1'b0, 1'b0);
        repeat (7) step(1'b1, 1'b1, 4'h0, 1'b1, 1'b1);
        step(1'b1, 1'b0, 4'hf, 1'b0, 1'b0);
        step(1'b1, 1'b1, 4'h0, 1'b1, 1'b0);
        step(1'b1, 1'b1, 4'h0, 1'b0, 1'b1);
        step(1'b0, 1'b0, 4'h9, 1'b1, 1'b1);
        casc_en <= 1'b1;
        repeat (40) step(1'b1, 1'b1, 4'h0, 1'b1, 1'b1);
        casc_en <= 1'b0;
        short_en <= 1'b1;
        short_val <= 4'h9;
        repeat (25) step(1'b1, 1'b1, 4'h0, 1'b1, 1'b1);
        short_en <= 1'b0;
        step(1'b1, 1'b1, 4'h0, 1'b0, 1'b0);
        axw(SPC_OFF_PRESET, 32'h5, SPC_RESP_OKAY);
        axr(SPC_OFF_PRESET, 32'h5, SPC_RESP_OKAY);
        axr(SPC_OFF_CTRL, 32'h0, SPC_RESP_OKAY);
        axw(SPC_OFF_CTRL, 32'h2, SPC_RESP_OKAY);
        axr(SPC_OFF_STATUS, 32'h5, SPC_RESP_OKAY);
        kgate <= 1'b1;
        axw(SPC_OFF_PRESET, 32'hf, SPC_RESP_OKAY);
        axw(SPC_OFF_CTRL, 32'h2, SPC_RESP_OKAY);
        axr(SPC_OFF_STATUS, 32'h3f, SPC_RESP_OKAY);
        axw(SPC_OFF_STATUS, 32'h0, SPC_RESP_SLVERR);
        axw(4'hc, 32'h1, SPC_RESP_SLVERR);
        axr(4'hc, 32'h0, SPC_RESP_SLVERR);
        axw(SPC_OFF_CTRL, 32'h1, SPC_RESP_OKAY);
        axr(SPC_OFF_STATUS, 32'h20, SPC_RESP_OKAY);
        // Byte lane 0 masked off: the preset must keep its old value
        wstrb <= 4'h0;
        axw(SPC_OFF_PRESET, 32'h3, SPC_RESP_OKAY);
        wstrb <= 4'hf;
        axr(SPC_OFF_PRESET, 32'hf, SPC_RESP_OKAY);
        ref_cnt = SPC_ZERO;
        step(1'b1, 1'b1, 4'h0, 1'b1, 1'b1);
        step(1'b1, 1'b1, 4'h0, 1'b0, 1'b0);
        conclude();
    end
endmodule : spc_counter_top_tb
